// File: hdl/irq_state_pkg.sv
// Overview of operation
// - trigger register write pends interrupt named in bits [8:0]; upper bits read zero
// - unprivileged trigger writes allowed only while the unprivileged-pend permit bit is 1
// - only privileged software may change the unprivileged-pend permit bit
// - one trigger register serves both security states, no banked copy
// - pulse inputs sampled on rising clock edge, detected pulse latched as pending
// - asserted level request line pends the interrupt while it is not active
// - a low-to-high transition on a request line pends the interrupt
// - writing 1 to a set-pending bank bit pends that interrupt
// - service routine entry clears pending and marks the interrupt active
// - level interrupt on return: pending if line asserted, otherwise inactive
// - pulse during service routine gives active-and-pending, then pending on return
// - pulse interrupt with no new pulse returns to inactive on routine exit
// - clear-pending on level interrupt with line asserted leaves state unchanged
// - clear-pending on pulse: pending to inactive, active-and-pending to active
// - disabled interrupts may still become pending; enable only gates taking
// - global mask set and cleared by core instructions blocks taking interrupts
// - clear-pending write 1 keeps active state; write 0 does nothing
// - set-pending on pending interrupt no effect; set-pending read shows pending
// - readable active bit per interrupt, number 32n+m across banks of 32
package irq_state_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int IRQ_COUNT = 480;
    localparam int BANK_COUNT = 15;
    localparam int ADDR_W = 12;
    localparam int NUM_W = 9;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] SET_PEND_BASE = 12'h000;
    localparam logic [11:0] CLR_PEND_BASE = 12'h080;
    localparam logic [11:0] ACTIVE_BASE = 12'h100;
    localparam logic [11:0] CFG_CTRL_ADDR = 12'h180;
    localparam logic [11:0] SW_TRIG_ADDR = 12'h184;
    localparam logic [11:0] STATUS_ADDR = 12'h188;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int UNPRIV_PERMIT_BIT = 1;
    localparam int GLOBAL_MASK_BIT = 0;
    localparam int TRIG_NUM_LSB = 0;
    localparam int PROT_PRIV_BIT = 0;
    localparam logic CFG_PERMIT_RESET = 1'b0;
    localparam logic GLOBAL_MASK_RESET = 1'b0;

    // per-interrupt state, bit 0 pending, bit 1 active
    typedef enum logic [1:0] {
        ST_INACTIVE = 2'b00,
        ST_PENDING = 2'b01,
        ST_ACTIVE = 2'b10,
        ST_ACT_PEND = 2'b11
    } irq_state_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [2:0] pprot;
    } apb_req_t;

    // core service routine entry or return
    typedef struct packed {
        logic valid;
        logic [NUM_W-1:0] num;
    } core_event_t;

endpackage : irq_state_pkg

// File: hdl/irq_state_cell.sv
`timescale 1ns/1ps
`default_nettype none
module irq_state_cell (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // peripheral request pin and type
    input wire logic req_line_i,
    input wire logic is_pulse_i,
    // software and core events
    input wire logic sw_set_i,
    input wire logic sw_clr_i,
    input wire logic enter_i,
    input wire logic return_i,
    // state
    output logic pending_o,
    output logic active_o
);

    logic sync1_q;
    logic line_q;
    logic line_prev_q;
    irq_state_pkg::irq_state_t state_q;
    logic pend_d;
    logic act_d;
    logic rise;

    // two-flop synchroniser plus edge history
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= 1'b0;
            line_q <= 1'b0;
            line_prev_q <= 1'b0;
        end else begin
            sync1_q <= req_line_i;
            line_q <= sync1_q;
            line_prev_q <= line_q;
        end
    end

    assign rise = line_q && !line_prev_q;

    // next state: clear, then entry/return, then sets win
    always_comb begin
        pend_d = state_q[0];
        act_d = state_q[1];
        if (sw_clr_i) begin
            if (is_pulse_i || !line_q) begin
                pend_d = 1'b0;
            end
        end
        if (enter_i) begin
            pend_d = 1'b0;
            act_d = 1'b1;
        end else if (return_i) begin
            act_d = 1'b0;
            if (!is_pulse_i) begin
                pend_d = 1'b0;
            end
        end
        if (sw_set_i) begin
            pend_d = 1'b1;
        end
        // any rising edge pends, level lines too, even while active
        if (rise) begin
            pend_d = 1'b1;
        end
        if (!is_pulse_i && line_q && !act_d) begin
            pend_d = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= irq_state_pkg::ST_INACTIVE;
        end else begin
            case ({act_d, pend_d})
                2'b01: state_q <= irq_state_pkg::ST_PENDING;
                2'b10: state_q <= irq_state_pkg::ST_ACTIVE;
                2'b11: state_q <= irq_state_pkg::ST_ACT_PEND;
                default: state_q <= irq_state_pkg::ST_INACTIVE;
            endcase
        end
    end

    assign pending_o = state_q[0];
    assign active_o = state_q[1];

endmodule : irq_state_cell
`default_nettype wire

// File: hdl/irq_pend_state_logic.sv
`timescale 1ns/1ps
`default_nettype none
module irq_pend_state_logic (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire irq_state_pkg::apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // peripheral request lines and their type
    input wire logic [irq_state_pkg::IRQ_COUNT-1:0] irq_line_i,
    input wire logic [irq_state_pkg::IRQ_COUNT-1:0] irq_is_pulse_i,
    input wire logic [irq_state_pkg::IRQ_COUNT-1:0] irq_enable_i,
    // core events
    input wire irq_state_pkg::core_event_t enter_i,
    input wire irq_state_pkg::core_event_t return_i,
    input wire logic global_irq_mask_instr_i,
    input wire logic global_irq_unmask_instr_i,
    // state towards the core
    output logic [irq_state_pkg::IRQ_COUNT-1:0] irq_pending_o,
    output logic [irq_state_pkg::IRQ_COUNT-1:0] irq_active_o,
    output logic [irq_state_pkg::IRQ_COUNT-1:0] irq_takeable_o,
    output logic global_mask_o
);

    localparam int N = irq_state_pkg::IRQ_COUNT;
    localparam int NB = irq_state_pkg::BANK_COUNT;

    // ****************************************
    // helpers
    // ****************************************

    // bank index when addr falls in base..base+4*NB-1, else NB
    function automatic logic [3:0] bank_of(input logic [11:0] addr, input logic [11:0] base);
        logic [11:0] off;
        off = addr - base;
        if (addr >= base && off[11:2] < 10'(NB)) begin
            bank_of = off[5:2];
        end else begin
            bank_of = 4'(NB);
        end
    endfunction : bank_of

    logic permit_q;
    logic mask_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [N-1:0] pend;
    logic [N-1:0] act;
    logic [N-1:0] sw_set;
    logic [N-1:0] sw_clr;
    logic [N-1:0] enter_hit;
    logic [N-1:0] return_hit;
    logic priv;
    logic access;
    logic wr_fire;
    logic [3:0] set_bank;
    logic [3:0] clr_bank;
    logic [3:0] act_bank;
    logic is_cfg;
    logic is_trig;
    logic is_stat;
    logic mapped;
    logic allowed;
    logic [31:0] rd_word;
    logic [irq_state_pkg::NUM_W-1:0] trig_num;

    // ****************************************
    // apb decode
    // ****************************************

    // address and privilege decode
    always_comb begin
        priv = apb_i.pprot[irq_state_pkg::PROT_PRIV_BIT];
        access = apb_i.psel && apb_i.penable;
        set_bank = bank_of(apb_i.paddr, irq_state_pkg::SET_PEND_BASE);
        clr_bank = bank_of(apb_i.paddr, irq_state_pkg::CLR_PEND_BASE);
        act_bank = bank_of(apb_i.paddr, irq_state_pkg::ACTIVE_BASE);
        is_cfg = apb_i.paddr == irq_state_pkg::CFG_CTRL_ADDR;
        is_trig = apb_i.paddr == irq_state_pkg::SW_TRIG_ADDR;
        is_stat = apb_i.paddr == irq_state_pkg::STATUS_ADDR;
        mapped = (set_bank != 4'(NB)) || (clr_bank != 4'(NB)) || (act_bank != 4'(NB))
            || is_cfg || is_trig || is_stat;
        // misaligned addresses fall outside every decode
        mapped = mapped && (apb_i.paddr[1:0] == 2'b00);
        allowed = priv || (is_trig && apb_i.pwrite && permit_q);
        wr_fire = access && pready_q && apb_i.pwrite && mapped && allowed;
        trig_num = apb_i.pwdata[irq_state_pkg::TRIG_NUM_LSB +: irq_state_pkg::NUM_W];
    end

    // read mux, unmapped and trigger read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (set_bank != 4'(NB)) begin
            rd_word = pend[32*set_bank +: 32];
        end else if (clr_bank != 4'(NB)) begin
            rd_word = pend[32*clr_bank +: 32];
        end else if (act_bank != 4'(NB)) begin
            rd_word = act[32*act_bank +: 32];
        end else if (is_cfg) begin
            rd_word[irq_state_pkg::UNPRIV_PERMIT_BIT] = permit_q;
        end else if (is_stat) begin
            rd_word[irq_state_pkg::GLOBAL_MASK_BIT] = mask_q;
        end
    end

    // one wait state: answer registered, pready high on the second access cycle
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            pready_q <= 1'b1;
            prdata_q <= (!apb_i.pwrite && mapped && allowed) ? rd_word : 32'h0000_0000;
            pslverr_q <= !(mapped && allowed);
        end else begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    assign pready_o = pready_q;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;

    // ****************************************
    // configuration and global mask
    // ****************************************

    // permit bit, privileged writes only reach here
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            permit_q <= irq_state_pkg::CFG_PERMIT_RESET;
        end else if (wr_fire && is_cfg) begin
            permit_q <= apb_i.pwdata[irq_state_pkg::UNPRIV_PERMIT_BIT];
        end
    end

    // global mask from core instructions, mask wins
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_q <= irq_state_pkg::GLOBAL_MASK_RESET;
        end else if (global_irq_mask_instr_i) begin
            mask_q <= 1'b1;
        end else if (global_irq_unmask_instr_i) begin
            mask_q <= 1'b0;
        end
    end

    assign global_mask_o = mask_q;

    // ****************************************
    // per-interrupt events
    // ****************************************

    // set and clear vectors from bank writes, trigger and core
    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        enter_hit = '0;
        return_hit = '0;
        if (wr_fire && set_bank != 4'(NB)) begin
            sw_set[32*set_bank +: 32] = apb_i.pwdata;
        end
        if (wr_fire && clr_bank != 4'(NB)) begin
            sw_clr[32*clr_bank +: 32] = apb_i.pwdata;
        end
        if (wr_fire && is_trig && 32'(trig_num) < 32'(N)) begin
            sw_set[trig_num] = 1'b1;
        end
        if (enter_i.valid && 32'(enter_i.num) < 32'(N)) begin
            enter_hit[enter_i.num] = 1'b1;
        end
        if (return_i.valid && 32'(return_i.num) < 32'(N)) begin
            return_hit[return_i.num] = 1'b1;
        end
    end

    // one state cell per interrupt
    for (genvar g = 0; g < N; g++) begin : g_cell
        irq_state_cell u_cell (
            .core_clk_i(core_clk_i),
            .resetn_i(resetn_i),
            .req_line_i(irq_line_i[g]),
            .is_pulse_i(irq_is_pulse_i[g]),
            .sw_set_i(sw_set[g]),
            .sw_clr_i(sw_clr[g]),
            .enter_i(enter_hit[g]),
            .return_i(return_hit[g]),
            .pending_o(pend[g]),
            .active_o(act[g])
        );
    end

    // ****************************************
    // outputs to the core
    // ****************************************

    assign irq_pending_o = pend;
    assign irq_active_o = act;

    // enable and mask gate only taking, never pending
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_takeable_o <= '0;
        end else begin
            irq_takeable_o <= pend & irq_enable_i & {N{!mask_q}};
        end
    end

endmodule : irq_pend_state_logic
`default_nettype wire

// File: sim/irq_pend_state_properties.sv
`timescale 1ns/1ps
`default_nettype none
module irq_pend_state_properties (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // register bus
    input wire irq_state_pkg::apb_req_t apb_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // core side
    input wire logic [irq_state_pkg::IRQ_COUNT-1:0] irq_enable_i,
    input wire irq_state_pkg::core_event_t enter_i,
    input wire irq_state_pkg::core_event_t return_i,
    input wire logic global_irq_mask_instr_i,
    input wire logic global_irq_unmask_instr_i,
    input wire logic [irq_state_pkg::IRQ_COUNT-1:0] irq_pending_o,
    input wire logic [irq_state_pkg::IRQ_COUNT-1:0] irq_active_o,
    input wire logic [irq_state_pkg::IRQ_COUNT-1:0] irq_takeable_o,
    input wire logic global_mask_o
);
    // ****************************************
    // helpers
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [8:0] ent_q;
    logic [8:0] ret_q;
    logic [8:0] trig_q;
    logic trig_ok;
    // numbers of last cycle, for next-cycle checks
    always_ff @(posedge core_clk_i) begin
        ent_q <= enter_i.num;
        ret_q <= return_i.num;
        trig_q <= apb_i.pwdata[8:0];
    end
    // accepted trigger write naming an implemented interrupt
    assign trig_ok = pready_o && !pslverr_o && apb_i.pwrite && apb_i.pwdata[8:0] < 9'h1e0
        && apb_i.paddr == irq_state_pkg::SW_TRIG_ADDR;

    // ****************************************
    // properties
    // ****************************************
    AST_TRIG_PENDS: assert property (trig_ok |=> irq_pending_o[trig_q])
        else $error("trigger write did not pend");
    AST_UNPRIV_REFUSED: assert property (
        pready_o && !apb_i.pprot[0] && !(apb_i.pwrite && apb_i.paddr == 12'h184) |-> pslverr_o)
        else $error("unprivileged access not refused");
    AST_UNALIGNED: assert property (pready_o && apb_i.paddr[1:0] != 2'h0 |-> pslverr_o)
        else $error("unaligned access not refused");
    AST_ENTER_ACTIVE: assert property (enter_i.valid |=> irq_active_o[ent_q])
        else $error("entry did not mark active");
    AST_RETURN_IDLE: assert property (
        return_i.valid && !enter_i.valid |=> !irq_active_o[ret_q])
        else $error("return left interrupt active");
    AST_MASK_SET: assert property (global_irq_mask_instr_i |=> global_mask_o)
        else $error("mask not set");
    AST_MASK_CLR: assert property (
        global_irq_unmask_instr_i && !global_irq_mask_instr_i |=> !global_mask_o)
        else $error("mask not cleared");
    AST_TAKEABLE: assert property (
        irq_takeable_o == ($past(irq_pending_o) & $past(irq_enable_i)
        & {480{!$past(global_mask_o)}}))
        else $error("takeable does not follow pending, enable and mask");
endmodule : irq_pend_state_properties

bind irq_pend_state_logic irq_pend_state_properties i_irq_pend_state_properties (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .apb_i(apb_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_enable_i(irq_enable_i), .enter_i(enter_i),
    .return_i(return_i), .global_irq_mask_instr_i(global_irq_mask_instr_i),
    .global_irq_unmask_instr_i(global_irq_unmask_instr_i), .irq_pending_o(irq_pending_o),
    .irq_active_o(irq_active_o), .irq_takeable_o(irq_takeable_o),
    .global_mask_o(global_mask_o)
);
`default_nettype wire

// File: sim/irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    // clock
    input wire logic core_clk_i,
    // request pins and core events
    output var logic [irq_state_pkg::IRQ_COUNT-1:0] line_o,
    output var irq_state_pkg::core_event_t enter_o,
    output var irq_state_pkg::core_event_t return_o
);
    // ****************************************
    // peripherals and core
    // ****************************************
    // quiet at start
    initial begin
        line_o = '0;
        enter_o = '0;
        return_o = '0;
    end
    // pulse held whole cycles, never under one
    task automatic pulse(input int n, input int len);
        line_o[n] <= 1'b1;
        repeat (len < 1 ? 1 : len) @(posedge core_clk_i);
        line_o[n] <= 1'b0;
    endtask : pulse
    // level request driven to v and held until the next level call
    task automatic level(input int n, input logic v);
        line_o[n] <= v;
    endtask : level
    // one-cycle entry or return carrying the number
    task automatic core_evt(input bit ent, input int n);
        if (ent) enter_o <= {1'b1, n[8:0]};
        else return_o <= {1'b1, n[8:0]};
        @(posedge core_clk_i);
        enter_o <= '0;
        return_o <= '0;
    endtask : core_evt
endmodule : irq_source_model
`default_nettype wire

// File: sim/test_irq_pend_state_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_irq_pend_state_logic;
    logic core_clk_i, resetn_i, pready_o, pslverr_o, serr;
    irq_state_pkg::apb_req_t apb_i;
    logic [31:0] prdata_o, rdata, w;
    logic [479:0] irq_line_i, irq_is_pulse_i, irq_enable_i, pend_m, act_m;
    logic [479:0] irq_pending_o, irq_active_o, irq_takeable_o;
    irq_state_pkg::core_event_t enter_i, return_i;
    logic global_irq_mask_instr_i, global_irq_unmask_instr_i, global_mask_o;
    int err_count, compares;

    // ****************************************
    // design and far side
    // ****************************************
    irq_pend_state_logic i_irq_pend_state_logic (.core_clk_i, .resetn_i, .apb_i, .prdata_o,
        .pready_o, .pslverr_o, .irq_line_i, .irq_is_pulse_i, .irq_enable_i, .enter_i,
        .return_i, .global_irq_mask_instr_i, .global_irq_unmask_instr_i, .irq_pending_o,
        .irq_active_o, .irq_takeable_o, .global_mask_o);
    irq_source_model i_irq_source_model (.core_clk_i, .line_o(irq_line_i), .enter_o(enter_i),
        .return_o(return_i));
    // clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        report_and_stop();
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [479:0] seen, input logic [479:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d, input bit pv);
        bit done;
        done = 0;
        apb_i <= {1'b1, 1'b0, wr, a, d, 2'b00, pv};
        @(posedge core_clk_i);
        apb_i.penable <= 1'b1;
        repeat (16) if (!done) begin
            @(posedge core_clk_i);
            done = (pready_o === 1'b1);
        end
        if (!done) check(1, 0);
        rdata = prdata_o;
        serr = pslverr_o;
        apb_i <= '0;
        @(posedge core_clk_i);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input bit e);
        apb(0, a, 0, 1);
        check(rdata, exp);
        check(serr, e);
    endtask : rd
    // compare both state vectors with the model
    task automatic both();
        check(irq_pending_o, pend_m);
        check(irq_active_o, act_m);
    endtask : both
    task automatic core(input bit ent, input int n);
        i_irq_source_model.core_evt(ent, n);
        act_m[n] = ent;
        pend_m[n] = ent ? 1'b0 : (irq_is_pulse_i[n] ? pend_m[n] : irq_line_i[n]);
        @(posedge core_clk_i);
        both();
    endtask : core
    // kind: 0 drop, 1 raise, 2 and 3 pulses of one and two cycles
    task automatic drive(input int n, input int kind);
        if (kind >= 2) i_irq_source_model.pulse(n, kind - 1);
        else i_irq_source_model.level(n, kind[0]);
        repeat (4) @(posedge core_clk_i);
        if (kind >= 1) pend_m[n] = 1'b1;
        both();
    endtask : drive
    task automatic clr(input int n);
        apb(1, irq_state_pkg::CLR_PEND_BASE + 12'(4 * (n / 32)), 1 << (n % 32), 1);
        if (irq_is_pulse_i[n] || !irq_line_i[n]) pend_m[n] = 1'b0;
        both();
    endtask : clr
    task automatic report_and_stop();
        $display("mismatches %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(70078));
        {apb_i, resetn_i, global_irq_mask_instr_i, global_irq_unmask_instr_i} = '0;
        {pend_m, act_m, err_count, compares} = '0;
        for (int i = 0; i < 15; i++) begin
            irq_is_pulse_i[i*32 +: 32] = $urandom();
            irq_enable_i[i*32 +: 32] = $urandom();
        end
        irq_is_pulse_i[5] = 1'b1;
        irq_is_pulse_i[7] = 1'b0;
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(posedge core_clk_i);
        rd(irq_state_pkg::CFG_CTRL_ADDR, 0, 0);
        rd(irq_state_pkg::STATUS_ADDR, 0, 0);
        rd(irq_state_pkg::SW_TRIG_ADDR, 0, 0);
        apb(1, irq_state_pkg::SW_TRIG_ADDR, 5, 0);
        check(serr, 1);
        apb(1, irq_state_pkg::CFG_CTRL_ADDR, 2, 0);
        rd(irq_state_pkg::CFG_CTRL_ADDR, 0, 0);
        apb(1, irq_state_pkg::CFG_CTRL_ADDR, 2, 1);
        rd(irq_state_pkg::CFG_CTRL_ADDR, 2, 0);
        apb(1, irq_state_pkg::SW_TRIG_ADDR, 480, 1);
        apb(1, irq_state_pkg::SW_TRIG_ADDR, 511, 0);
        both();
        // random triggers, either privilege, noisy reserved bits
        repeat (8) begin
            w = $urandom();
            w[8:0] = 9'($urandom_range(479, 0));
            apb(1, irq_state_pkg::SW_TRIG_ADDR, w, w[31]);
            check(serr, 0);
            pend_m[w[8:0]] = 1'b1;
        end
        both();
        for (int b = 0; b < 15; b++) begin
            w = $urandom();
            apb(1, irq_state_pkg::SET_PEND_BASE + 12'(4 * b), w, 1);
            pend_m[b*32 +: 32] |= w;
            rd(irq_state_pkg::SET_PEND_BASE + 12'(4 * b), pend_m[b*32 +: 32], 0);
            w = $urandom();
            apb(1, irq_state_pkg::CLR_PEND_BASE + 12'(4 * b), w, 1);
            pend_m[b*32 +: 32] &= ~w;
            rd(irq_state_pkg::CLR_PEND_BASE + 12'(4 * b), pend_m[b*32 +: 32], 0);
        end
        check(irq_takeable_o, pend_m & irq_enable_i);
        // mask and unmask together: mask wins
        global_irq_mask_instr_i <= 1'b1;
        global_irq_unmask_instr_i <= 1'b1;
        @(posedge core_clk_i);
        {global_irq_mask_instr_i, global_irq_unmask_instr_i} <= 2'b00;
        repeat (2) @(posedge core_clk_i);
        check(irq_takeable_o, 0);
        rd(irq_state_pkg::STATUS_ADDR, 1, 0);
        global_irq_unmask_instr_i <= 1'b1;
        @(posedge core_clk_i);
        global_irq_unmask_instr_i <= 1'b0;
        @(posedge core_clk_i);
        check(global_mask_o, 0);
        for (int b = 0; b < 480; b++) if (pend_m[b]) clr(b);
        // pulse interrupt through its states
        drive(5, 2);
        core(1, 5);
        drive(5, 3);
        clr(5);
        drive(5, 2);
        core(0, 5);
        clr(5);
        drive(5, 2);
        core(1, 5);
        core(0, 5);
        // level interrupt
        drive(7, 1);
        clr(7);
        core(1, 7);
        apb(1, irq_state_pkg::ACTIVE_BASE, 32'hffffffff, 1);
        rd(irq_state_pkg::ACTIVE_BASE, act_m[31:0], 0);
        core(0, 7);
        core(1, 7);
        drive(7, 0);
        core(0, 7);
        // level line rising while its routine runs
        core(1, 7);
        drive(7, 1);
        core(0, 7);
        drive(7, 0);
        clr(7);
        rd(12'h181, 0, 1);
        rd(12'h1fc, 0, 1);
        report_and_stop();
    end
endmodule : test_irq_pend_state_logic
`default_nettype wire
